// [pkg/sse_pkg.sv]
/*
 * Shared constants and types of the stack and shift execute block.
 * Assumes a 16-bit core with a word-wide data memory on the stack side.
 */
package sse_pkg;
	// Data and address width of the core
	localparam int DW = 16;

	// Status word bit positions
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_GIE = 3;
	localparam int SR_PROCESSOR_OFF_BIT = 4;
	localparam int SR_OSCILLATOR_OFF_BIT = 5;
	localparam int SR_V = 8;

	// Reset values
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] SR_RESET = 16'h0000;

	// Stack step, always a word
	localparam logic [15:0] STACK_STEP = 16'h0002;

	// Overflow windows of the left shifts, value before the shift
	localparam logic [15:0] OVF_WORD_LO = 16'h4000;
	localparam logic [15:0] OVF_WORD_HI = 16'hc000;
	localparam logic [7:0] OVF_BYTE_LO = 8'h40;
	localparam logic [7:0] OVF_BYTE_HI = 8'hc0;

	// Cycle counts of the no-operation stand-ins
	localparam logic [3:0] CYC_MOV_IDX = 4'h6;
	localparam logic [3:0] CYC_MOV_IND = 4'h5;
	localparam logic [3:0] CYC_JMP_NEXT = 4'h2;

	// Watchdog control address
	localparam logic [15:0] WDT_CTL_ADDR = 16'h0120;

	// Instruction classes handled here
	typedef enum logic [3:0] {
		OP_POP = 4'h0,
		OP_PUSH = 4'h1,
		OP_RET = 4'h2,
		OP_INTERRUPT_RETURN = 4'h3,
		OP_RLA = 4'h4,
		OP_RLC = 4'h5,
		OP_RRA = 4'h6,
		OP_MOV_IDX = 4'h7,
		OP_MOV_IND = 4'h8,
		OP_JMP_NEXT = 4'h9
	} sse_op_t;

	// Sequencer states, Gray along idle-read-read
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_READ1 = 3'h1,
		ST_READ2 = 3'h3,
		ST_WRITE = 3'h2,
		ST_WAIT = 3'h6
	} sse_state_t;

	// Command from the decoder
	typedef struct packed {
		sse_op_t op;
		logic byteOp;
		logic dstIsReg;
		logic [15:0] srcVal;
		logic [15:0] dstVal;
		logic [15:0] dataAddr;
	} sse_cmd_t;

	// Result toward the destination writer
	typedef struct packed {
		logic [15:0] data;
		logic byteOp;
		logic toReg;
	} sse_res_t;

	// Left-shift overflow window on the value before the shift
	function automatic logic sse_ovf_window(input logic [15:0] v,
		input logic isByte);
		if (isByte) begin
			sse_ovf_window = (v[7:0] >= OVF_BYTE_LO) &&
				(v[7:0] < OVF_BYTE_HI);
		end else begin
			sse_ovf_window = (v >= OVF_WORD_LO) && (v < OVF_WORD_HI);
		end
	endfunction
endpackage

// [core/sse_shift_unit.sv]
/*
 * Combinational shift and rotate datapath with its flag results.
 * Assumes the caller registers result and flags and feeds the old carry.
 */
`timescale 1ns/10ps
module sse_shift_unit import sse_pkg::*; (
	// Operation
	input wire sse_op_t op,
	input wire logic byteOp,
	// Operands
	input wire logic [15:0] dstVal,
	input wire logic carryIn,
	// Results
	output logic [15:0] result,
	output logic flagN,
	output logic flagZ,
	output logic flagC,
	output logic flagV
);
	logic [15:0] wide;
	logic msb;

	// One-place shifts; byte forms work on the low byte only
	always_comb begin
		wide = byteOp ? {8'h00, dstVal[7:0]} : dstVal;
		msb = byteOp ? dstVal[7] : dstVal[15];
		result = wide;
		flagC = 1'b0;
		flagV = 1'b0;
		case (op)
			OP_RLA: begin
				result = {wide[14:0], 1'b0};
				flagC = msb;
				flagV = sse_ovf_window(dstVal, byteOp);
			end
			OP_RLC: begin
				result = {wide[14:0], carryIn};
				flagC = msb;
				flagV = sse_ovf_window(dstVal, byteOp);
			end
			OP_RRA: begin
				// Sign bit stays, so this is a signed halving
				result = byteOp ? {8'h00, dstVal[7], dstVal[7:1]} :
					{dstVal[15], dstVal[15:1]};
				flagC = dstVal[0];
				flagV = 1'b0;
			end
			default: begin
				result = wide;
			end
		endcase
		// Upper byte of a byte result is cleared
		if (byteOp) begin
			result[15:8] = 8'h00;
		end
		flagN = byteOp ? result[7] : result[15];
		flagZ = byteOp ? (result[7:0] == 8'h00) : (result == 16'h0000);
	end
endmodule // sse_shift_unit

// [core/sse_cycle_timer.sv]
/*
 * Down counter that marks the last cycle of a fixed-length instruction.
 * Assumes start is a one-cycle pulse and load is at least one.
 */
`timescale 1ns/10ps
module sse_cycle_timer import sse_pkg::*; #(
	parameter int CW = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Control
	input wire logic start,
	input wire logic [CW-1:0] load,
	// Status
	output logic last
);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	// Load on start, then count down to zero and stop
	always_comb begin
		cnt_nxt = cnt_r;
		if (start) begin
			cnt_nxt = load;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - CW'(1);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign last = (cnt_r == CW'(1)) && !start;
endmodule // sse_cycle_timer

// [core/sse_execute.sv]
/*
 * Execute sequencer for stack instructions, single-place shifts and the
 * fixed-length no-operation stand-ins.
 * Assumes a decoder that presents one command at a time and a stack memory
 * that answers each request with a one-cycle acknowledge.
 */
`timescale 1ns/10ps
// Function
// - pop reads top word, steps pointer, writes destination
// - byte pop moves only the low byte
// - byte pop into register clears upper byte
// - pop always adds two to pointer
// - push lowers pointer first, then writes word
// - push always subtracts two from pointer
// - pop, push, return keep arithmetic flags
// - return loads counter from stack, adds two
// - interrupt return loads status, then counter
// - interrupt return restores flags and mode bits
// - left shift doubles, old top into carry
// - left shift overflow on value window
// - rotate left inserts carry, top into carry
// - rotate left uses same overflow windows
// - left shifts: sign, zero, carry from width
// - right shift keeps sign, halves signed
// - right shift: carry gets bottom, overflow clear
// - byte right shift clears register upper byte
// - only interrupt return changes mode bits
// - stand-ins take six, five, two cycles
// - keyless watchdog write raises security violation
module sse_execute import sse_pkg::*; #(
	// Arbitrary key value standing for the watchdog password
	parameter logic [7:0] WDT_KEY = 8'h3c
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Command from the decoder
	input wire logic cmdValid,
	input wire sse_cmd_t cmd,
	output logic cmdReady,
	// Result and completion
	output logic resValid,
	output sse_res_t res,
	output logic instrDone,
	output logic securityViolation,
	// Stack memory
	output logic memReq,
	output logic memWe,
	output logic [15:0] memAddr,
	output logic [15:0] memWdata,
	input wire logic [15:0] memRdata,
	input wire logic memAck,
	// Architectural state
	output logic [15:0] stackPointer,
	output logic [15:0] programCounter,
	output logic [15:0] statusWord
);
	sse_state_t state_r, state_nxt;
	sse_op_t curOp_r, curOp_nxt;
	logic curByte_r, curByte_nxt;
	logic curReg_r, curReg_nxt;
	logic [15:0] curSrc_r, curSrc_nxt;
	logic [15:0] curAddr_r, curAddr_nxt;
	logic [15:0] sp_r, sp_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [15:0] sr_r, sr_nxt;
	logic ready_r, ready_nxt;
	logic resValid_r, resValid_nxt;
	sse_res_t res_r, res_nxt;
	logic done_r, done_nxt;
	logic viol_r, viol_nxt;
	logic memReq_r, memReq_nxt;
	logic memWe_r, memWe_nxt;
	logic [15:0] memAddr_r, memAddr_nxt;
	logic [15:0] memWdata_r, memWdata_nxt;
	logic accept;
	logic timerStart;
	logic [3:0] timerLoad;
	logic timerLast;
	logic [15:0] shResult;
	logic shN, shZ, shC, shV;

	assign accept = cmdValid && ready_r;

	// Shift datapath works straight on the incoming command
	sse_shift_unit u_shift (
		.op(cmd.op),
		.byteOp(cmd.byteOp),
		.dstVal(cmd.dstVal),
		.carryIn(sr_r[SR_C]),
		.result(shResult),
		.flagN(shN),
		.flagZ(shZ),
		.flagC(shC),
		.flagV(shV)
	);

	// Cycle budget of the stand-ins
	sse_cycle_timer #(.CW(4)) u_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(timerStart),
		.load(timerLoad),
		.last(timerLast)
	);

	// Timer load picks the stand-in length
	always_comb begin
		timerStart = 1'b0;
		timerLoad = CYC_JMP_NEXT;
		if (accept) begin
			case (cmd.op)
				// Done is registered, so the timer runs one cycle short
				OP_MOV_IDX: begin
					timerStart = 1'b1;
					timerLoad = CYC_MOV_IDX - 4'h1;
				end
				OP_MOV_IND: begin
					timerStart = 1'b1;
					timerLoad = CYC_MOV_IND - 4'h1;
				end
				OP_JMP_NEXT: begin
					timerStart = 1'b1;
					timerLoad = CYC_JMP_NEXT - 4'h1;
				end
				default: begin
					timerStart = 1'b0;
				end
			endcase
		end
	end

	// Sequencer next state; flags only move on shifts and interrupt return
	always_comb begin
		state_nxt = state_r;
		curOp_nxt = curOp_r;
		curByte_nxt = curByte_r;
		curReg_nxt = curReg_r;
		curSrc_nxt = curSrc_r;
		curAddr_nxt = curAddr_r;
		sp_nxt = sp_r;
		pc_nxt = pc_r;
		sr_nxt = sr_r;
		ready_nxt = ready_r;
		resValid_nxt = 1'b0;
		res_nxt = res_r;
		done_nxt = 1'b0;
		viol_nxt = 1'b0;
		memReq_nxt = memReq_r;
		memWe_nxt = memWe_r;
		memAddr_nxt = memAddr_r;
		memWdata_nxt = memWdata_r;
		case (state_r)
			ST_IDLE: begin
				if (accept) begin
					curOp_nxt = cmd.op;
					curByte_nxt = cmd.byteOp;
					curReg_nxt = cmd.dstIsReg;
					curSrc_nxt = cmd.srcVal;
					curAddr_nxt = cmd.dataAddr;
					case (cmd.op)
						OP_POP, OP_RET, OP_INTERRUPT_RETURN: begin
							// Word read at the pointer
							memReq_nxt = 1'b1;
							memWe_nxt = 1'b0;
							memAddr_nxt = sp_r;
							ready_nxt = 1'b0;
							state_nxt = ST_READ1;
						end
						OP_PUSH: begin
							// Pointer drops before the word goes out
							sp_nxt = sp_r - STACK_STEP;
							memReq_nxt = 1'b1;
							memWe_nxt = 1'b1;
							memAddr_nxt = sp_r - STACK_STEP;
							// Byte push still writes a full word
							memWdata_nxt = cmd.byteOp ?
								{8'h00, cmd.srcVal[7:0]} : cmd.srcVal;
							ready_nxt = 1'b0;
							state_nxt = ST_WRITE;
						end
						OP_RLA, OP_RLC, OP_RRA: begin
							// Single-cycle shift, mode bits kept
							res_nxt.data = shResult;
							res_nxt.byteOp = cmd.byteOp;
							res_nxt.toReg = cmd.dstIsReg;
							resValid_nxt = 1'b1;
							done_nxt = 1'b1;
							sr_nxt[SR_N] = shN;
							sr_nxt[SR_Z] = shZ;
							sr_nxt[SR_C] = shC;
							sr_nxt[SR_V] = shV;
						end
						OP_MOV_IDX, OP_MOV_IND, OP_JMP_NEXT: begin
							ready_nxt = 1'b0;
							state_nxt = ST_WAIT;
						end
						default: begin
							state_nxt = ST_IDLE;
						end
					endcase
				end
			end
			ST_READ1: begin
				if (memAck) begin
					memReq_nxt = 1'b0;
					sp_nxt = sp_r + STACK_STEP;
					case (curOp_r)
						OP_POP: begin
							// Byte pop keeps only the low byte
							res_nxt.data = curByte_r ?
								{8'h00, memRdata[7:0]} : memRdata;
							res_nxt.byteOp = curByte_r;
							res_nxt.toReg = curReg_r;
							resValid_nxt = 1'b1;
							done_nxt = 1'b1;
							ready_nxt = 1'b1;
							state_nxt = ST_IDLE;
						end
						OP_RET: begin
							pc_nxt = memRdata;
							done_nxt = 1'b1;
							ready_nxt = 1'b1;
							state_nxt = ST_IDLE;
						end
						OP_INTERRUPT_RETURN: begin
							// Whole stacked word, mode bits too
							sr_nxt = memRdata;
							memReq_nxt = 1'b1;
							memAddr_nxt = sp_r + STACK_STEP;
							state_nxt = ST_READ2;
						end
						default: begin
							ready_nxt = 1'b1;
							state_nxt = ST_IDLE;
						end
					endcase
				end
			end
			ST_READ2: begin
				if (memAck) begin
					memReq_nxt = 1'b0;
					pc_nxt = memRdata;
					sp_nxt = sp_r + STACK_STEP;
					done_nxt = 1'b1;
					ready_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			ST_WRITE: begin
				if (memAck) begin
					memReq_nxt = 1'b0;
					memWe_nxt = 1'b0;
					done_nxt = 1'b1;
					ready_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			ST_WAIT: begin
				if (timerLast) begin
					// A move onto the watchdog without key still trips it
					viol_nxt = (curOp_r != OP_JMP_NEXT) &&
						(curAddr_r == WDT_CTL_ADDR) &&
						(curSrc_r[15:8] != WDT_KEY);
					done_nxt = 1'b1;
					ready_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				memReq_nxt = 1'b0;
				ready_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Register stage of the sequencer
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			curOp_r <= OP_POP;
			curByte_r <= 1'b0;
			curReg_r <= 1'b0;
			curSrc_r <= 16'h0000;
			curAddr_r <= 16'h0000;
			sp_r <= SP_RESET;
			pc_r <= PC_RESET;
			sr_r <= SR_RESET;
			ready_r <= 1'b1;
			resValid_r <= 1'b0;
			res_r <= '0;
			done_r <= 1'b0;
			viol_r <= 1'b0;
			memReq_r <= 1'b0;
			memWe_r <= 1'b0;
			memAddr_r <= 16'h0000;
			memWdata_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			curOp_r <= curOp_nxt;
			curByte_r <= curByte_nxt;
			curReg_r <= curReg_nxt;
			curSrc_r <= curSrc_nxt;
			curAddr_r <= curAddr_nxt;
			sp_r <= sp_nxt;
			pc_r <= pc_nxt;
			sr_r <= sr_nxt;
			ready_r <= ready_nxt;
			resValid_r <= resValid_nxt;
			res_r <= res_nxt;
			done_r <= done_nxt;
			viol_r <= viol_nxt;
			memReq_r <= memReq_nxt;
			memWe_r <= memWe_nxt;
			memAddr_r <= memAddr_nxt;
			memWdata_r <= memWdata_nxt;
		end
	end

	// Outputs straight from flops
	assign cmdReady = ready_r;
	assign resValid = resValid_r;
	assign res = res_r;
	assign instrDone = done_r;
	assign securityViolation = viol_r;
	assign memReq = memReq_r;
	assign memWe = memWe_r;
	assign memAddr = memAddr_r;
	assign memWdata = memWdata_r;
	assign stackPointer = sp_r;
	assign programCounter = pc_r;
	assign statusWord = sr_r;

	// Pop finishing its read steps the pointer by two
	property p_pop_step;
		@(posedge core_clk) disable iff (sys_rst)
		(state_r == ST_READ1 && memAck && curOp_r == OP_POP) |=>
			(sp_r == $past(sp_r) + STACK_STEP) && resValid_r;
	endproperty
	a_pop_step: assert property (p_pop_step)
		else $error("pop did not step pointer by two");

	// Byte pop into a register has a clear upper byte
	property p_pop_byte;
		@(posedge core_clk) disable iff (sys_rst)
		(resValid_r && res_r.byteOp && res_r.toReg) |->
			(res_r.data[15:8] == 8'h00);
	endproperty
	a_pop_byte: assert property (p_pop_byte)
		else $error("byte result upper byte not cleared");

	// Push lowers the pointer and writes at the new pointer
	property p_push_order;
		@(posedge core_clk) disable iff (sys_rst)
		(accept && cmd.op == OP_PUSH) |=>
			(sp_r == $past(sp_r) - STACK_STEP) && memReq_r && memWe_r &&
			(memAddr_r == sp_r);
	endproperty
	a_push_order: assert property (p_push_order)
		else $error("push write not at lowered pointer");

	// Flags hold while a stack operation other than interrupt return runs
	property p_flags_kept;
		@(posedge core_clk) disable iff (sys_rst)
		(state_r != ST_IDLE && curOp_r != OP_INTERRUPT_RETURN) |=> $stable(sr_r);
	endproperty
	a_flags_kept: assert property (p_flags_kept)
		else $error("status changed during stack operation");

	// Return takes the counter from the read word
	property p_ret_pc;
		@(posedge core_clk) disable iff (sys_rst)
		(state_r == ST_READ1 && memAck && curOp_r == OP_RET) |=>
			(pc_r == $past(memRdata)) && instrDone;
	endproperty
	a_ret_pc: assert property (p_ret_pc)
		else $error("return did not load counter");

	// Interrupt return loads status, then reads the next word
	property p_interrupt_return_seq;
		@(posedge core_clk) disable iff (sys_rst)
		(state_r == ST_READ1 && memAck && curOp_r == OP_INTERRUPT_RETURN) |=>
			(sr_r == $past(memRdata)) && (state_r == ST_READ2) &&
			(memAddr_r == $past(sp_r) + STACK_STEP);
	endproperty
	a_interrupt_return_seq: assert property (p_interrupt_return_seq)
		else $error("interrupt return sequence wrong");

	// Stack requests use even word addresses
	property p_even_addr;
		@(posedge core_clk) disable iff (sys_rst)
		memReq_r |-> (memAddr_r[0] == 1'b0);
	endproperty
	a_even_addr: assert property (p_even_addr)
		else $error("odd stack address");

	// Left shifts set overflow exactly on the window
	property p_left_ovf;
		@(posedge core_clk) disable iff (sys_rst)
		(accept && (cmd.op == OP_RLA || cmd.op == OP_RLC)) |=>
			(sr_r[SR_V] == sse_ovf_window($past(cmd.dstVal),
				$past(cmd.byteOp)));
	endproperty
	a_left_ovf: assert property (p_left_ovf)
		else $error("left shift overflow wrong");

	// Right shift clears overflow and keeps mode bits
	property p_rra_flags;
		@(posedge core_clk) disable iff (sys_rst)
		(accept && cmd.op == OP_RRA) |=> !sr_r[SR_V] &&
			(sr_r[SR_C] == $past(cmd.dstVal[0])) &&
			(sr_r[SR_OSCILLATOR_OFF_BIT:SR_GIE] == $past(sr_r[SR_OSCILLATOR_OFF_BIT:SR_GIE]));
	endproperty
	a_rra_flags: assert property (p_rra_flags)
		else $error("right shift flags wrong");

	// Jump stand-in completes two cycles after acceptance
	property p_jmp_time;
		@(posedge core_clk) disable iff (sys_rst)
		(accept && cmd.op == OP_JMP_NEXT) |=> !instrDone ##1 instrDone;
	endproperty
	a_jmp_time: assert property (p_jmp_time)
		else $error("jump stand-in length wrong");

	// Indexed move stand-in completes six cycles after acceptance
	property p_idx_time;
		@(posedge core_clk) disable iff (sys_rst)
		(accept && cmd.op == OP_MOV_IDX) |=> !instrDone [*5] ##1 instrDone;
	endproperty
	a_idx_time: assert property (p_idx_time)
		else $error("indexed move stand-in length wrong");

	// Keyless move to the watchdog raises the violation at completion
	property p_wdt_viol;
		@(posedge core_clk) disable iff (sys_rst)
		(accept && cmd.op == OP_MOV_IND && cmd.dataAddr == WDT_CTL_ADDR &&
			cmd.srcVal[15:8] != WDT_KEY) |=> ##4 securityViolation;
	endproperty
	a_wdt_viol: assert property (p_wdt_viol)
		else $error("missing security violation");
endmodule // sse_execute

// [tb/sse_stack_mem.sv]
/*
 * Stack side of the data memory, a behavioural word store.
 * Assumes requests from the core change just after a rising edge and
 * stand until acknowledged; answers are given just after a falling edge.
 */
`timescale 1ns/10ps
module sse_stack_mem (
	// Clock
	input wire logic core_clk,
	// Request from the core
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [15:0] memAddr,
	input wire logic [15:0] memWdata,
	// Answer pacing and answer
	input wire logic [3:0] ackDelay,
	output logic [15:0] memRdata,
	output logic memAck
);
	logic [15:0] mem [logic [15:0]];
	int waitCnt;

	// Quiet memory at time zero
	initial begin
		memAck = 1'b0;
		memRdata = 16'h5a5a;
		waitCnt = 0;
	end

	// One-cycle acknowledge after a chosen delay
	always @(negedge core_clk) begin
		if (memAck) begin
			memAck <= 1'b0;
			memRdata <= ~memRdata; // Stale data must never look valid
			waitCnt <= 0;
		end else if (memReq && waitCnt >= int'(ackDelay)) begin
			memAck <= 1'b1;
			if (memWe) begin
				mem[memAddr] = memWdata;
			end
			if (!memWe && mem.exists(memAddr)) begin
				memRdata <= mem[memAddr];
			end else begin
				memRdata <= ~memRdata;
			end
		end else begin
			memRdata <= ~memRdata; // Toggles so no value settles by chance
			waitCnt <= memReq ? waitCnt + 1 : 0;
		end
	end
endmodule // sse_stack_mem

// [tb/stack_and_shift_execute_tb_top.sv]
/*
 * Self-checking bench of the execute sequencer with a reference model.
 * Assumes the stack memory model beside it and the default watchdog key.
 */
`timescale 1ns/10ps
module stack_and_shift_execute_tb_top import sse_pkg::*; ;
	localparam logic [7:0] KEY = 8'h3c; // Arbitrary, same as design default
	logic core_clk, sys_rst, cmdValid, cmdReady, resValid, instrDone;
	logic securityViolation, memReq, memWe, memAck;
	sse_cmd_t cmd;
	sse_res_t res;
	logic [15:0] memAddr, memWdata, memRdata, stackPointer;
	logic [15:0] programCounter, statusWord, seed, eSp, eSr, v;
	logic [3:0] ackDelay;
	logic [15:0] stk [$];
	logic [15:0] vals [11] = '{16'h3fff, 16'h4000, 16'hbfff, 16'hc000,
		16'h0000, 16'h8000, 16'h003f, 16'h0040, 16'h00bf, 16'h00c0, 16'h0001};
	sse_op_t shOps [3] = '{OP_RLA, OP_RLC, OP_RRA};
	sse_op_t nops [3] = '{OP_MOV_IDX, OP_MOV_IND, OP_JMP_NEXT};
	int cyc [3] = '{6, 5, 2};
	int miscompares, samplesChecked, cycles, n;

	sse_execute #(.WDT_KEY(KEY)) u_dut (.core_clk(core_clk),
		.sys_rst(sys_rst), .cmdValid(cmdValid), .cmd(cmd),
		.cmdReady(cmdReady), .resValid(resValid), .res(res),
		.instrDone(instrDone), .securityViolation(securityViolation),
		.memReq(memReq), .memWe(memWe), .memAddr(memAddr),
		.memWdata(memWdata), .memRdata(memRdata), .memAck(memAck),
		.stackPointer(stackPointer), .programCounter(programCounter),
		.statusWord(statusWord));

	sse_stack_mem u_mem (.core_clk(core_clk), .memReq(memReq),
		.memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
		.ackDelay(ackDelay), .memRdata(memRdata), .memAck(memAck));

	// 40 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic closeOut();
		$display("samplesChecked %0d miscompares %0d", samplesChecked,
			miscompares);
		if (miscompares == 0 && samplesChecked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected value at %0t: got %h expected %h", $time,
				got, exp);
		end
	endtask

	// One command, waits for its completion; n counts cycles taken
	task automatic run(input sse_op_t op, input logic b,
		input logic [15:0] s, input logic [15:0] d, input logic [15:0] a);
		@(negedge core_clk);
		cmd = '{op: op, byteOp: b, dstIsReg: seed[0], srcVal: s, dstVal: d,
			dataAddr: a};
		cmdValid = 1'b1;
		n = 0;
		while (cmdReady !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		@(negedge core_clk);
		cmdValid = 1'b0;
		n = 1;
		while (instrDone !== 1'b1 && n < 60) begin
			@(negedge core_clk);
			n++;
		end
		check({15'h0000, instrDone}, 16'h0001);
	endtask

	task automatic doPush(input logic [15:0] s, input logic b);
		logic [15:0] w;
		w = b ? {8'h00, s[7:0]} : s;
		run(OP_PUSH, b, s, 16'h0000, 16'h0000);
		eSp = eSp - 16'h0002;
		stk.push_front(w);
		check(stackPointer, eSp);
		check(u_mem.mem[eSp], w);
		check(statusWord, eSr);
	endtask

	task automatic doPop(input logic b);
		logic [15:0] w;
		run(OP_POP, b, 16'h0000, 16'h0000, 16'h0000);
		w = stk.pop_front();
		eSp = eSp + 16'h0002;
		check(res.data, b ? {8'h00, w[7:0]} : w);
		check({15'h0000, resValid}, 16'h0001);
		check(16'({res.byteOp, res.toReg}), 16'({b, cmd.dstIsReg}));
		check(stackPointer, eSp);
		check(statusWord, eSr);
	endtask

	task automatic doRet(input logic intr);
		run(intr ? OP_INTERRUPT_RETURN : OP_RET, 1'b0, 16'h0000, 16'h0000, 16'h0000);
		if (intr) begin
			eSr = stk.pop_front();
			eSp = eSp + 16'h0002;
		end
		eSp = eSp + 16'h0002;
		check(programCounter, stk.pop_front());
		check(stackPointer, eSp);
		check(statusWord, eSr);
	endtask

	task automatic doShift(input sse_op_t op, input logic b,
		input logic [15:0] d);
		logic [15:0] x, r;
		logic t, cin, ov;
		x = b ? {8'h00, d[7:0]} : d;
		t = b ? x[7] : x[15];
		cin = (op == OP_RLC) & eSr[SR_C];
		ov = b ? (x >= 16'h0040 && x < 16'h00c0) :
			(x >= 16'h4000 && x < 16'hc000);
		if (op == OP_RRA) begin
			r = b ? {8'h00, t, x[7:1]} : {t, x[15:1]};
			eSr[SR_C] = x[0];
			ov = 1'b0;
		end else begin
			r = b ? {8'h00, x[6:0], cin} : {x[14:0], cin};
			eSr[SR_C] = t;
		end
		eSr[SR_V] = ov;
		eSr[SR_N] = b ? r[7] : r[15];
		eSr[SR_Z] = (r == 16'h0000);
		run(op, b, 16'h0000, d, 16'h0000);
		check(16'(n), 16'h0001);
		check(res.data, r);
		check(16'({res.byteOp, res.toReg}), 16'({b, cmd.dstIsReg}));
		check(statusWord, eSr);
	endtask

	// Run-length ceiling
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			closeOut();
		end
	end

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		cmdValid = 1'b0;
		cmd = '0;
		ackDelay = 4'h0;
		seed = 16'h0009;
		miscompares = 0;
		samplesChecked = 0;
		cycles = 0;
		eSp = 16'h0000;
		eSr = 16'h0000;
		repeat (2) @(negedge core_clk);
		sys_rst = 1'b0;
		check(stackPointer, eSp);
		check(statusWord, eSr);
		check({15'h0000, cmdReady}, 16'h0001);
		// Stack traffic with prompt and slow memory
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			ackDelay = {2'b00, seed[1:0]};
			doPush(seed, i[0]);
		end
		doPop(1'b1);
		ackDelay = 4'h3;
		doPop(1'b0);
		doPush(16'h1234, 1'b0);
		doRet(1'b0);
		doPush(16'h2468, 1'b0);
		doPush(16'h0139, 1'b0);
		doRet(1'b1);
		// Shifts over window edges and random operands
		for (int k = 0; k < 16; k++) begin
			seed = lfsr(seed);
			v = (k < 11) ? vals[k] : seed;
			for (int j = 0; j < 6; j++) begin
				doShift(shOps[j % 3], j > 2, j > 2 ? {seed[15:8], v[7:0]} : v);
			end
		end
		// Timing stand-ins, keyed watchdog writes are harmless
		for (int j = 0; j < 3; j++) begin
			seed = lfsr(seed);
			run(nops[j], 1'b0, {KEY, seed[7:0]}, 16'h0000, 16'h0120);
			check(16'(n), 16'(cyc[j]));
			check({15'h0000, securityViolation}, 16'h0000);
			check(stackPointer, eSp);
		end
		run(OP_MOV_IND, 1'b0, {~KEY, seed[7:0]}, 16'h0000, 16'h0120);
		check({15'h0000, securityViolation}, 16'h0001);
		run(OP_MOV_IDX, 1'b0, {~KEY, seed[7:0]}, 16'h0000, 16'h0120);
		check({15'h0000, securityViolation}, 16'h0001);
		run(OP_MOV_IDX, 1'b0, {~KEY, seed[7:0]}, 16'h0000, 16'h0122);
		check({15'h0000, securityViolation}, 16'h0000);
		run(OP_JMP_NEXT, 1'b0, {~KEY, seed[7:0]}, 16'h0000, 16'h0120);
		check({15'h0000, securityViolation}, 16'h0000);
		closeOut();
	end
endmodule // stack_and_shift_execute_tb_top
